// *** logic/dsbm_master.sv ***
// dma system bus master with synchronous and asynchronous bus protocols
//
// Overview of operation
// - in synchronous mode parity strap high selects even parity submode, low selects no parity
// - low order data byte goes to the lowest byte address
// - first state drives address, cycle type and address status together
// - ready ignored in first state, sampled in second, wait states until ready
// - reads float the data bus, latch data and parity on ready
// - writes drive data and parity from second clock of first state until after ready
// - sync bus fault ends cycle; config read fails action, tx read aborts frame
// - parity check output low for one clock after latch on bad parity
// - drive hold when needed; on grant use it or pass it down the cascade
// - no new hold request until the grant has dropped after a tenure
// - grant withdrawn mid cycle ends cycle as fault, bus released later
// - first access starts within four clocks of the grant
// - async write: address strobe first, data strobe one clock later
// - async read: data strobe with address strobe, latch at cycle end
// - async cycle ends on acknowledge from third clock, strobes drop first
// - async bus fault ends cycle; failed read interrupts and aborts tx
// - async: pull bus request low; on grant acknowledge it or pass it on
// - async: no new request until bus request and grant acknowledge are high
// - first async cycle one clock after grant acknowledge, release drops it
// - receive before transmit before channel action requests
// - every pending access is done in the same tenure unless the grant is withdrawn mid cycle
// - one system clock times the bus, each cycle at least four clocks
// - static mode pin selects synchronous or asynchronous protocol
`timescale 1ns/1ps
module dsbm_master
	import dsbm_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic mode_async,
	input wire logic parity_strap,
	input wire logic [DSBM_NUM_CLASSES-1:0] req_valid,
	input wire logic [DSBM_NUM_CLASSES-1:0] req_write,
	input wire logic [DSBM_NUM_CLASSES-1:0][DSBM_ADDR_W-1:0] req_addr,
	input wire logic [DSBM_NUM_CLASSES-1:0][1:0] req_section,
	input wire logic [DSBM_NUM_CLASSES-1:0][DSBM_DATA_W-1:0] req_wdata,
	output logic [DSBM_NUM_CLASSES-1:0] req_done,
	output logic req_fault,
	output logic [DSBM_DATA_W-1:0] rd_data,
	output logic action_fail_irq,
	output logic frame_abort_interrupt,
	output logic read_fault_irq,
	output logic [DSBM_ADDR_W-1:0] bus_address,
	output logic [3:0] byte_enable_n,
	output logic bus_write,
	output logic bus_ctl_oe_n,
	input wire logic [DSBM_DATA_W-1:0] data_in,
	output logic [DSBM_DATA_W-1:0] data_out,
	output logic data_oe_n,
	input wire logic [DSBM_LANES-1:0] byte_parity_lines_in,
	output logic [DSBM_LANES-1:0] byte_parity_lines_out,
	output logic byte_parity_oe_n,
	output logic parity_check_n,
	output logic address_status_n,
	input wire logic ready_n,
	input wire logic bus_fault_n,
	output logic hold_request,
	input wire logic ownership_granted,
	output logic ownership_grant_out,
	output logic address_strobe_n,
	output logic data_strobe_n,
	input wire logic transfer_acknowledge_n,
	input wire logic bus_request_in_n,
	output logic bus_request_out_n,
	output logic bus_request_oe_n,
	input wire logic bus_grant_n,
	input wire logic grant_acknowledge_in_n,
	output logic grant_acknowledge_out_n,
	output logic grant_acknowledge_oe_n,
	output logic grant_out_n
);

	dsbm_state_type state_q, state_d;
	logic [1:0] cls_q, cls_d;
	logic [1:0] sec_q, sec_d;
	logic [1:0] drop_cnt_q, drop_cnt_d;
	logic wr_q, wr_d;
	logic block_q, block_d;
	logic fault_q, fault_d;
	logic drop_q, drop_d;
	logic gack_q, gack_d;
	logic parity_check_n_q, parity_check_n_d;
	logic act_fail_q, act_fail_d;
	logic frame_abort_q, frame_abort_d;
	logic read_fault_q, read_fault_d;
	logic [DSBM_NUM_CLASSES-1:0] done_q, done_d;
	logic [DSBM_ADDR_W-1:0] addr_q, addr_d;
	logic [DSBM_DATA_W-1:0] wdata_q, wdata_d;
	logic [DSBM_DATA_W-1:0] rdata_q, rdata_d;
	logic [DSBM_LANES-1:0] rpar_q, rpar_d;
	logic [DSBM_LANES-1:0] wpar;
	logic [DSBM_LANES-1:0] lane_bad;
	logic any_req;
	logic [1:0] sel;
	logic sync_mode;
	logic parity_en;
	logic in_sync_cycle;
	logic load;
	logic bus_free;
	logic [DSBM_NUM_CLASSES-1:0] arb_req;

	// the class ending now is masked, its valid only drops after req_done
	always_comb begin
		arb_req = req_valid;
		if (state_q == st_end) begin
			arb_req[cls_q] = 1'b0;
		end
	end

	dsbm_prio_arb #(
		.NUM_REQ(DSBM_NUM_CLASSES)
	) u_arb (
		.req(arb_req),
		.any_req(any_req),
		.sel(sel)
	);

	// mode pin picks the protocol, parity only exists in synchronous mode
	// strap high means even parity checking and generation
	assign sync_mode = ~mode_async;
	assign parity_en = sync_mode & parity_strap;
	assign in_sync_cycle = (state_q == st_s1a) || (state_q == st_s1b) || (state_q == st_s2);

	// lane i carries bits 8i+7..8i at byte address base+i, so the bus is little endian
	// even parity per lane: data byte xor its parity bit must be zero
	for (genvar i = 0; i < DSBM_LANES; i++) begin : g_lane
		assign wpar[i] = ^wdata_q[8*i +: 8];
		assign lane_bad[i] = ^{rdata_q[8*i +: 8], rpar_q[i]};
	end

	// the bus is free again once the previous tenure's grant lines settle
	assign bus_free = sync_mode ? ~ownership_granted
		: (bus_request_in_n & grant_acknowledge_in_n);

	// controller next state, one process for all access state
	always_comb begin
		state_d = state_q;
		cls_d = cls_q;
		sec_d = sec_q;
		wr_d = wr_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		rpar_d = rpar_q;
		block_d = block_q;
		fault_d = fault_q;
		drop_d = drop_q;
		drop_cnt_d = drop_cnt_q;
		gack_d = gack_q;
		parity_check_n_d = 1'b1;
		act_fail_d = 1'b0;
		frame_abort_d = 1'b0;
		read_fault_d = 1'b0;
		done_d = '0;
		load = 1'b0;
		case (state_q)
			st_idle: begin
				// anti blocking: hold back until the old grant is gone
				if (block_q && bus_free) begin
					block_d = 1'b0;
				end
				if (any_req && !block_q) begin
					state_d = st_request;
				end
			end
			st_request: begin
				// own grant taken, first cycle starts on the next clock
				if (sync_mode && ownership_granted) begin
					load = 1'b1;
					state_d = st_s1a;
				// acknowledge the grant and let go of the request together
				end else if (!sync_mode && !bus_grant_n) begin
					gack_d = 1'b1;
					state_d = st_own;
				end
			end
			st_own: begin
				// first async cycle one clock after the grant acknowledge
				load = 1'b1;
				state_d = st_a1;
			end
			st_s1a: begin
				state_d = st_s1b;
			end
			st_s1b: begin
				state_d = st_s2;
			end
			st_s2: begin
				// ready only counts here and in the wait states that follow
				if (!bus_fault_n) begin
					fault_d = 1'b1;
					state_d = st_end;
				end else if (!ready_n) begin
					// read data and parity caught on the ready clock
					rdata_d = data_in;
					rpar_d = byte_parity_lines_in;
					fault_d = 1'b0;
					state_d = st_end;
				end
			end
			st_a1: begin
				state_d = st_a2;
			end
			st_a2: begin
				state_d = st_a3;
			end
			st_a3: begin
				// acknowledge or fault ends the cycle, waits otherwise
				if (!bus_fault_n || !transfer_acknowledge_n) begin
					rdata_d = data_in;
					fault_d = ~bus_fault_n;
					state_d = st_end;
				end
			end
			st_end: begin
				done_d[cls_q] = 1'b1;
				// one low clock on bad parity, nothing else happens
				parity_check_n_d = ~(parity_en && !wr_q && !fault_q && (|lane_bad));
				// reaction to a synchronous fault depends on the section
				if (fault_q && sync_mode && !wr_q) begin
					act_fail_d = (sec_q == DSBM_SEC_CONFIG);
					frame_abort_d = (sec_q == DSBM_SEC_TXDATA);
				end
				// failed asynchronous read interrupts and aborts its tx channel
				if (fault_q && !sync_mode && !wr_q) begin
					read_fault_d = 1'b1;
					frame_abort_d = 1'b1;
				end
				if (drop_q) begin
					drop_cnt_d = DSBM_DROP_CYCLES;
					state_d = st_drop;
				// keep the bus while anything is still queued
				end else if (any_req) begin
					load = 1'b1;
					state_d = sync_mode ? st_s1a : st_a1;
				end else begin
					// release and drop the grant acknowledge at once
					gack_d = 1'b0;
					block_d = 1'b1;
					state_d = st_idle;
				end
			end
			st_drop: begin
				// keep driving a few clocks after the grant fell, then let go
				drop_cnt_d = drop_cnt_q - 2'h1;
				if (drop_cnt_q == 2'h1) begin
					drop_d = 1'b0;
					block_d = 1'b1;
					state_d = st_idle;
				end
			end
			default: begin
				state_d = st_idle;
			end
		endcase
		// a grant withdrawn mid cycle turns the cycle into a fault
		if (sync_mode && in_sync_cycle && !ownership_granted) begin
			fault_d = 1'b1;
			drop_d = 1'b1;
			state_d = st_end;
		end
		// the arbiter hands the highest priority class
		if (load) begin
			cls_d = sel;
			wr_d = req_write[sel];
			addr_d = req_addr[sel];
			sec_d = req_section[sel];
			wdata_d = req_wdata[sel];
			fault_d = 1'b0;
		end
	end

	// controller registers on the single system clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= st_idle;
			cls_q <= DSBM_CLS_RX;
			sec_q <= DSBM_SEC_OTHER;
			wr_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			rpar_q <= '0;
			block_q <= 1'b0;
			fault_q <= 1'b0;
			drop_q <= 1'b0;
			drop_cnt_q <= 2'h0;
			gack_q <= 1'b0;
			parity_check_n_q <= 1'b1;
			act_fail_q <= 1'b0;
			frame_abort_q <= 1'b0;
			read_fault_q <= 1'b0;
			done_q <= '0;
		end else begin
			state_q <= state_d;
			cls_q <= cls_d;
			sec_q <= sec_d;
			wr_q <= wr_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			rpar_q <= rpar_d;
			block_q <= block_d;
			fault_q <= fault_d;
			drop_q <= drop_d;
			drop_cnt_q <= drop_cnt_d;
			gack_q <= gack_d;
			parity_check_n_q <= parity_check_n_d;
			act_fail_q <= act_fail_d;
			frame_abort_q <= frame_abort_d;
			read_fault_q <= read_fault_d;
			done_q <= done_d;
		end
	end

	// user side answers
	assign req_done = done_q;
	assign req_fault = fault_q;
	assign rd_data = rdata_q;
	assign action_fail_irq = act_fail_q;
	assign frame_abort_interrupt = frame_abort_q;
	assign read_fault_irq = read_fault_q;
	assign parity_check_n = parity_check_n_q;

	// address, cycle type and long word enables held valid while mastering
	assign bus_address = addr_q;
	assign bus_write = wr_q;
	assign byte_enable_n = DSBM_BE_LONGWORD;
	assign bus_ctl_oe_n = ~(in_sync_cycle || (state_q == st_a1) || (state_q == st_a2)
		|| (state_q == st_a3) || (state_q == st_end) || (state_q == st_drop));
	assign address_status_n = ~(state_q == st_s1a || state_q == st_s1b);

	// write data from the second clock of the first state through the end clock
	// async write data comes out with the address strobe, ahead of the data strobe
	assign data_out = wdata_q;
	assign data_oe_n = ~(wr_q && (state_q == st_s1b || state_q == st_s2 || state_q == st_end
		|| state_q == st_a1 || state_q == st_a2 || state_q == st_a3));
	assign byte_parity_lines_out = wpar;
	assign byte_parity_oe_n = data_oe_n | ~parity_en;

	// strobes; data strobe trails by a clock on writes, both drop at end
	assign address_strobe_n = ~(state_q == st_a1 || state_q == st_a2 || state_q == st_a3);
	assign data_strobe_n = ~((state_q == st_a1 && !wr_q) || state_q == st_a2
		|| state_q == st_a3);

	// hold stays up across the tenure; an unrequested grant is passed down
	assign hold_request = sync_mode && (state_q == st_request || in_sync_cycle
		|| state_q == st_end);
	assign ownership_grant_out = sync_mode && ownership_granted
		&& (state_q == st_idle || state_q == st_drop);

	// open drain request and acknowledge; the out values are always low
	assign bus_request_out_n = 1'b0;
	assign bus_request_oe_n = ~(!sync_mode && state_q == st_request);
	assign grant_acknowledge_out_n = 1'b0;
	assign grant_acknowledge_oe_n = ~gack_q;
	assign grant_out_n = (!sync_mode && state_q == st_idle) ? bus_grant_n : 1'b1;

	default clocking dsbm_cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_s1_two_clocks: assert property ($fell(address_status_n) |-> ##1 !address_status_n ##1 address_status_n)
		else $error("address status not two clocks");
	a_ready_ignored: assert property (state_q == st_s1b && ownership_granted |=> state_q == st_s2)
		else $error("ready honoured in first state");
	a_read_floats: assert property (!wr_q && !bus_ctl_oe_n |-> data_oe_n)
		else $error("data driven on read");
	a_write_window: assert property (state_q == st_s1b && wr_q |-> !data_oe_n ##1 !data_oe_n)
		else $error("write data not driven");
	a_parity_flag: assert property (state_q == st_end && parity_en && !wr_q && !fault_q
		&& (|lane_bad) |=> !parity_check_n ##1 parity_check_n)
		else $error("parity check pulse wrong");
	a_hold_blocked: assert property (block_q && ownership_granted && sync_mode |-> !hold_request)
		else $error("hold raised before grant dropped");
	a_grant_drop: assert property (sync_mode && in_sync_cycle && !ownership_granted
		|=> state_q == st_end ##1 !bus_ctl_oe_n [*3])
		else $error("bus released too early");
	a_start_bound: assert property (sync_mode && state_q == st_request && ownership_granted
		|-> ##[1:4] !address_status_n)
		else $error("first access too late");
	a_async_write: assert property (state_q == st_a1 && wr_q |-> data_strobe_n && !address_strobe_n
		##1 !data_strobe_n)
		else $error("write data strobe timing");
	a_async_read: assert property ($fell(address_strobe_n) && !wr_q |-> !data_strobe_n)
		else $error("read data strobe late");
	a_gack_start: assert property ($fell(grant_acknowledge_oe_n) |=> !address_strobe_n)
		else $error("first async cycle not one clock after acknowledge");
	a_prio_order: assert property (load && arb_req[DSBM_CLS_RX] |=> cls_q == DSBM_CLS_RX)
		else $error("receive class not served first");

	c_sync_wait: cover property (state_q == st_s2 ##1 state_q == st_s2 ##1 state_q == st_end);
	c_async_fault: cover property (state_q == st_a3 && !bus_fault_n);
	c_back_to_back: cover property (state_q == st_end ##1 state_q == st_s1a);

endmodule

// *** logic/dsbm_pkg.sv ***
// shared constants and types for the dma system bus master
package dsbm_pkg;

	// bus geometry
	localparam int DSBM_ADDR_W = 30;
	localparam int DSBM_DATA_W = 32;
	localparam int DSBM_LANES = 4;

	// request classes, index 0 is served first
	localparam int DSBM_NUM_CLASSES = 3;
	localparam logic [1:0] DSBM_CLS_RX = 2'h0;
	localparam logic [1:0] DSBM_CLS_TX = 2'h1;
	localparam logic [1:0] DSBM_CLS_ACTION = 2'h2;

	// memory section that an access touches, decides the reaction to a fault
	localparam logic [1:0] DSBM_SEC_CONFIG = 2'h0;
	localparam logic [1:0] DSBM_SEC_TXDATA = 2'h1;
	localparam logic [1:0] DSBM_SEC_OTHER = 2'h2;

	// byte enables for a full long word, all lanes active low
	localparam logic [3:0] DSBM_BE_LONGWORD = 4'h0;

	// clock and release delay after a withdrawn grant
	localparam int DSBM_CLK_HZ = 20_000_000;
	localparam logic [1:0] DSBM_DROP_CYCLES = 2'h3;

	// bus controller states
	typedef enum logic [3:0] {
		st_idle,
		st_request,
		st_own,
		st_s1a,
		st_s1b,
		st_s2,
		st_a1,
		st_a2,
		st_a3,
		st_end,
		st_drop
	} dsbm_state_type;

endpackage

// *** logic/dsbm_prio_arb.sv ***
// fixed priority picker for queued dma requests
`timescale 1ns/1ps
module dsbm_prio_arb
	import dsbm_pkg::*;
#(
	parameter int NUM_REQ = DSBM_NUM_CLASSES
) (
	input wire logic [NUM_REQ-1:0] req,
	output logic any_req,
	output logic [1:0] sel
);

	// the select is two bits wide, so at most four classes fit
	if (NUM_REQ < 1 || NUM_REQ > 4) begin : g_bad_num
		$error("dsbm_prio_arb: NUM_REQ must be 1 to 4");
	end

	// lowest index wins; scanning downward lets the last hit be the winner
	always_comb begin
		any_req = |req;
		sel = 2'h0;
		for (int i = NUM_REQ - 1; i >= 0; i--) begin
			if (req[i]) begin
				sel = 2'(i);
			end
		end
	end

endmodule

// *** test/dsbm_mem_model.sv ***
// far side model: shared memory, bus arbiter and cycle responder
`timescale 1ns/1ps
module dsbm_mem_model
	import dsbm_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic mode_async,
	input wire logic [3:0] wait_cycles,
	input wire logic inject_fault,
	input wire logic bad_parity,
	input wire logic revoke,
	input wire logic [DSBM_ADDR_W-1:0] bus_address,
	input wire logic bus_write,
	input wire logic [DSBM_DATA_W-1:0] data_out,
	input wire logic data_oe_n,
	input wire logic address_status_n,
	input wire logic address_strobe_n,
	input wire logic hold_request,
	input wire logic bus_request_oe_n,
	input wire logic grant_acknowledge_oe_n,
	output logic [DSBM_DATA_W-1:0] data_in,
	output logic [DSBM_LANES-1:0] byte_parity_lines_in,
	output logic ready_n,
	output logic bus_fault_n,
	output logic transfer_acknowledge_n,
	output logic ownership_granted,
	output logic bus_grant_n,
	output logic bus_request_in_n,
	output logic grant_acknowledge_in_n
);
	logic [DSBM_DATA_W-1:0] mem [16];
	logic [1:0] phase;
	logic [4:0] cnt;
	logic strobe_n;
	logic hold;
	assign strobe_n = mode_async ? address_strobe_n : address_status_n;
	assign hold = mode_async && phase[1];
	// pulled-up wired lines, only this master pulls them
	assign bus_request_in_n = bus_request_oe_n;
	assign grant_acknowledge_in_n = grant_acknowledge_oe_n;
	always_comb begin
		for (int i = 0; i < DSBM_LANES; i++) begin
			byte_parity_lines_in[i] = (^data_in[8*i +: 8]) ^ bad_parity;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 2'h0;
			cnt <= 5'h00;
			ready_n <= 1'b1;
			bus_fault_n <= 1'b1;
			transfer_acknowledge_n <= 1'b1;
			data_in <= 32'h0;
			ownership_granted <= 1'b0;
			bus_grant_n <= 1'b1;
			foreach (mem[i]) mem[i] <= {28'hC0FFEE0, 4'(i)};
		end else begin
			ownership_granted <= hold_request && !revoke;
			bus_grant_n <= bus_request_in_n;
			cnt <= cnt + 5'h01;
			if (!hold) begin
				ready_n <= 1'b1;
				bus_fault_n <= 1'b1;
				transfer_acknowledge_n <= 1'b1;
				data_in <= ~data_in; // released bus never shows stale data
			end
			case (phase)
				2'h0: begin
					cnt <= 5'h00;
					if (!strobe_n) phase <= 2'h1;
				end
				2'h1: begin
					if (!mode_async && !ownership_granted) phase <= 2'h0;
					else if (cnt == {1'b0, wait_cycles}) begin
						phase <= 2'h2;
						ready_n <= mode_async | inject_fault;
						transfer_acknowledge_n <= !mode_async | inject_fault;
						bus_fault_n <= !inject_fault;
						if (!bus_write) data_in <= mem[bus_address[3:0]];
					end
				end
				2'h2: begin
					// undriven write data never reaches memory
					if (bus_write && !inject_fault && !data_oe_n) mem[bus_address[3:0]] <= data_out;
					phase <= mode_async ? 2'h3 : 2'h0;
				end
				default: if (strobe_n) begin
					phase <= 2'h0;
					transfer_acknowledge_n <= 1'b1;
					bus_fault_n <= 1'b1;
				end
			endcase
		end
	end
endmodule

// *** test/test_dma_system_bus_master.sv ***
// self-checking bench: master against the shared memory model
`timescale 1ns/1ps
module test_dma_system_bus_master;
	import dsbm_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic mode_async = 1'b0;
	logic parity_strap = 1'b0;
	logic [2:0] req_valid = 3'h0;
	logic [2:0] req_write = 3'h0;
	logic [2:0][29:0] req_addr = '0;
	logic [2:0][1:0] req_section = '0;
	logic [2:0][31:0] req_wdata = '0;
	logic [3:0] wait_cycles = 4'h0;
	logic inject_fault = 1'b0;
	logic bad_parity = 1'b0;
	logic revoke = 1'b0;
	logic [2:0] req_done;
	logic [31:0] rd_data, data_in, data_out;
	logic [29:0] bus_address;
	logic [3:0] byte_enable_n, byte_parity_lines_in, byte_parity_lines_out;
	logic req_fault, action_fail_irq, frame_abort_interrupt, read_fault_irq, bus_write;
	logic bus_ctl_oe_n, data_oe_n, byte_parity_oe_n, parity_check_n, address_status_n;
	logic ready_n, bus_fault_n, hold_request, ownership_granted, ownership_grant_out;
	logic address_strobe_n, data_strobe_n, transfer_acknowledge_n, bus_request_in_n;
	logic bus_request_out_n, bus_request_oe_n, bus_grant_n, grant_acknowledge_in_n;
	logic grant_acknowledge_out_n, grant_acknowledge_oe_n, grant_out_n;
	logic tn_q = 1'b0;
	logic hold_q = 1'b0;
	logic ds_q = 1'b1;
	logic lat_open = 1'b0;
	logic [2:0] irq_seen = 3'h0;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	int tenures = 0;
	int parity_check_n_low = 0;
	int lat = 0;
	int max_lat = 0;
	int ds_lag = 0;
	int as_cnt = 0;
	int viol = 0;
	int par_drv = 0;
	int bad_par = 0;
	int order [$];
	wire tn = mode_async ? !grant_acknowledge_oe_n : ownership_granted;

	dsbm_master DUT (.*);
	dsbm_mem_model partner (.*);

	always #25 clk = ~clk;

	// tenures, grant latency, strobe spacing, pulses; also cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (tn && !tn_q) begin
			tenures++;
			lat = 0;
			lat_open = 1'b1;
		end else if (tn) lat++;
		if (!address_status_n && lat_open) begin
			lat_open = 1'b0;
			if (lat > max_lat) max_lat = lat;
		end
		if (hold_request && !hold_q && ownership_granted) viol++;
		if (!data_strobe_n && ds_q) ds_lag = as_cnt;
		if (address_strobe_n) as_cnt = 0;
		else as_cnt++;
		if (!parity_check_n) parity_check_n_low++;
		// driven lane parity must be even over the driven data
		if (!byte_parity_oe_n) begin
			par_drv++;
			if (byte_parity_lines_out !== {^data_out[31:24], ^data_out[23:16],
				^data_out[15:8], ^data_out[7:0]}) bad_par++;
		end
		// a grant is never passed on while this master holds the bus
		if (ownership_grant_out && !bus_ctl_oe_n) viol++;
		if (!grant_out_n && !grant_acknowledge_oe_n) viol++;
		irq_seen <= irq_seen | {read_fault_irq, frame_abort_interrupt, action_fail_irq};
		tn_q <= tn;
		hold_q <= hold_request;
		ds_q <= data_strobe_n;
		if (cycles == 8000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic restart(input logic a, input logic p);
		@(negedge clk);
		reset_n = 1'b0;
		mode_async = a;
		parity_strap = p;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		parity_check_n_low = 0;
	endtask

	// raise a set of classes, drop each in its done cycle
	task automatic run(input logic [2:0] m);
		@(negedge clk);
		req_valid = m;
		order = {};
		while (req_valid != 3'h0) begin
			@(negedge clk);
			for (int c = 0; c < 3; c++) if (req_done[c] === 1'b1 && req_valid[c]) begin
				req_valid[c] = 1'b0;
				order.push_back(c);
			end
		end
	endtask

	task automatic acc(input int c, input logic w, input logic [29:0] a,
			input logic [1:0] s, input logic [31:0] d);
		req_write[c] = w;
		req_addr[c] = a;
		req_section[c] = s;
		req_wdata[c] = d;
		run(3'h1 << c);
	endtask

	task automatic t_sync_data;
		restart(1'b0, 1'b1);
		wait_cycles = 4'h2;
		acc(1, 1'b1, 30'h3, DSBM_SEC_OTHER, 32'h1234ABCD);
		chk(par_drv > 0, 32'h1);
		chk(bad_par, 32'h0);
		chk({byte_enable_n, bus_request_out_n, grant_acknowledge_out_n}, 32'h0);
		acc(0, 1'b0, 30'h3, DSBM_SEC_OTHER, 32'h0);
		chk(rd_data, 32'h1234ABCD);
		chk(parity_check_n_low, 32'h0);
		wait_cycles = 4'h0;
		bad_parity = 1'b1;
		acc(2, 1'b0, 30'h5, DSBM_SEC_OTHER, 32'h0);
		repeat (3) @(negedge clk);
		bad_parity = 1'b0;
		chk(rd_data, 32'hC0FFEE05);
		chk(parity_check_n_low, 32'h1);
		$display("test sync_data done");
	endtask

	task automatic t_nopar;
		restart(1'b0, 1'b0);
		bad_parity = 1'b1;
		acc(0, 1'b0, 30'h6, DSBM_SEC_OTHER, 32'h0);
		repeat (3) @(negedge clk);
		bad_parity = 1'b0;
		chk(rd_data, 32'hC0FFEE06);
		chk(parity_check_n_low, 32'h0);
		$display("test no_parity done");
	endtask

	task automatic t_prio;
		req_write = 3'h0;
		req_section = {3{DSBM_SEC_OTHER}};
		req_addr = {30'h2, 30'h1, 30'h0};
		tenures = 0;
		max_lat = 0;
		run(3'h7);
		chk(order.size(), 32'h3);
		foreach (order[i]) chk(order[i], i);
		chk(tenures, 32'h1);
		chk(rd_data, 32'hC0FFEE02);
		if (!mode_async) chk(max_lat <= 4, 32'h1);
		$display("test priority done");
	endtask

	task automatic t_faults;
		logic [2:0] e;
		for (int s = 0; s < 4; s++) begin
			e = (s == 3) ? 3'h0 : mode_async ? 3'h6 : (s == 0) ? 3'h1 : (s == 1) ? 3'h2 : 3'h0;
			irq_seen = 3'h0;
			inject_fault = 1'b1;
			acc(0, s == 3, 30'h4, (s == 3) ? 2'h0 : s[1:0], 32'h0);
			inject_fault = 1'b0;
			repeat (2) @(negedge clk);
			chk(req_fault, 32'h1);
			chk(irq_seen, e);
		end
		$display("test faults done");
	endtask

	task automatic t_revoke;
		int k;
		k = 0;
		wait_cycles = 4'h8;
		fork
			acc(0, 1'b0, 30'h1, DSBM_SEC_OTHER, 32'h0);
			begin
				while (address_status_n !== 1'b0) @(negedge clk);
				revoke = 1'b1;
				while (bus_ctl_oe_n !== 1'b1 && k < 20) begin
					@(negedge clk);
					k++;
				end
			end
		join
		chk(req_fault, 32'h1);
		chk(k > 2 && k < 12, 32'h1);
		revoke = 1'b0;
		wait_cycles = 4'h0;
		$display("test revoke done");
	endtask

	task automatic t_async;
		restart(1'b1, 1'b0);
		wait_cycles = 4'h3;
		acc(1, 1'b1, 30'h9, DSBM_SEC_OTHER, 32'h5A5AC3C3);
		chk(ds_lag, 32'h1);
		acc(0, 1'b0, 30'h9, DSBM_SEC_OTHER, 32'h0);
		chk(ds_lag, 32'h0);
		chk(rd_data, 32'h5A5AC3C3);
		wait_cycles = 4'h0;
		$display("test async done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		t_sync_data();
		t_nopar();
		t_prio();
		t_faults();
		t_revoke();
		t_async();
		t_prio();
		t_faults();
		chk(viol, 32'h0);
		tally_and_finish();
	end
endmodule
